// ### rtl/gsr_pkg.sv
// Purpose: constants for the gripper status register bank
// Assumes: byte-wide status registers at byte offsets 0..5
// Notes: fault codes and field layouts shared by design and bench
package gsr_pkg;
  // register offsets
  localparam logic [3:0] OFF_STATE_FLAGS = 4'h0;
  localparam logic [3:0] OFF_RESERVED = 4'h1;
  localparam logic [3:0] OFF_FAULT = 4'h2;
  localparam logic [3:0] OFF_TARGET_ECHO = 4'h3;
  localparam logic [3:0] OFF_MEAS_POS = 4'h4;
  localparam logic [3:0] OFF_CURRENT = 4'h5;
  localparam logic [3:0] OFF_CMD = 4'h8;
  localparam logic [3:0] OFF_TARGET_REQ = 4'h9;
  localparam logic [3:0] OFF_SPEED_REQ = 4'ha;
  localparam logic [3:0] OFF_FORCE_REQ = 4'hb;
  // field positions in status byte zero
  localparam int BIT_ACT = 0;
  localparam int BIT_GTO = 3;
  localparam int POS_STA = 4;
  localparam int POS_OBJ = 6;
  // field positions in command byte
  localparam int CMD_ACT = 0;
  localparam int CMD_GTO = 3;
  localparam int CMD_ATR = 4;
  localparam int CMD_ARD = 5;
  // gripper state codes
  localparam logic [1:0] STA_RESET = 2'h0;
  localparam logic [1:0] STA_ACTIVATING = 2'h1;
  localparam logic [1:0] STA_ACTIVE = 2'h3;
  // object detection codes
  localparam logic [1:0] OBJ_MOVING = 2'h0;
  localparam logic [1:0] OBJ_OPEN_CONTACT = 2'h1;
  localparam logic [1:0] OBJ_CLOSE_CONTACT = 2'h2;
  localparam logic [1:0] OBJ_AT_TARGET = 2'h3;
  // fault codes
  localparam logic [3:0] FLT_NONE = 4'h0;
  localparam logic [3:0] FLT_DELAYED = 4'h5;
  localparam logic [3:0] FLT_NOT_ACTIVE = 4'h7;
  localparam logic [3:0] FLT_OVERTEMP = 4'h8;
  localparam logic [3:0] FLT_NO_COMM = 4'h9;
  localparam logic [3:0] FLT_UNDERVOLT = 4'ha;
  localparam logic [3:0] FLT_REL_BUSY = 4'hb;
  localparam logic [3:0] FLT_INTERNAL = 4'hc;
  localparam logic [3:0] FLT_ACT_FAIL = 4'hd;
  localparam logic [3:0] FLT_OVERCUR = 4'he;
  localparam logic [3:0] FLT_REL_DONE = 4'hf;
  localparam logic [3:0] FLT_MAJOR_MIN = 4'ha;
  localparam logic [3:0] FLT_MINOR_MIN = 4'h8;
  // force bands
  localparam logic [7:0] FORCE_HIGH_MIN = 8'h80;
  // timing
  localparam int CLK_HZ = 100_000_000;
  localparam int COMM_TIMEOUT_MS = 1000;
  localparam int COMM_TIMEOUT_CYC = CLK_HZ / 1000 * COMM_TIMEOUT_MS;
  localparam int BLINK_MS = 250;
  localparam int BLINK_CYC = CLK_HZ / 1000 * BLINK_MS;
endpackage : gsr_pkg

// ### rtl/gsr_status_regs.sv
// Purpose: status register bank and command decode of a two-finger gripper
// Assumes: motion engine and sensors are outside; they report through inputs
// Notes: plain register port, read data valid the cycle after the read strobe
// How it works
// (R1) activation echo mirrors activation command bit
// (R2) motion echo mirrors go-to command bit
// (R3) state field 0, 1 or 3; 2 unused
// (R4) object field 0 while moving, no contact
// (R5) object field 1 on contact while opening
// (R6) object field 2 on contact while closing
// (R7) object field 3 at target or object lost
// (R8) controller ignores object field when motion zero
// (R9) object field in bits 7:6 of byte zero
// (R10) priority faults 5 delayed, 7 not activated
// (R11) minor faults 8 overtemp, 9 comm silence 1s
// (R12) major faults hold until activation rising edge
// (R13) major codes 0xa..0xf, zero is no fault
// (R14) led blue, solid red, or blinking red/blue
// (R15) byte three echoes target position request
// (R16) byte four returns encoder finger position
// (R17) byte five returns motor current, 10mA/count
// (R18) force zero: lowest force, re-grasp off
// (R19) force 1..127: low torque, re-grasp on
// (R20) force 128..255: high torque, re-grasp on
// (R21) go-to starts move with speed and force
// (R22) no motion without go-to except activation/release
// (R23) finished auto release faults until reactivation
// (R24) general fault low nibble, controller fault high
// (R25) reserved byte and bits read zero
`timescale 1ns/10ps
`default_nettype none
module gsr_status_regs #(
  parameter int COMM_TIMEOUT_CYC = gsr_pkg::COMM_TIMEOUT_CYC,
  parameter int BLINK_CYC = gsr_pkg::BLINK_CYC
) (
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // motion engine handshake
  input wire logic activation_done,
  input wire logic activation_failed,
  input wire logic motion_stopped,
  input wire logic contact_detected,
  input wire logic closing_dir,
  input wire logic release_done,
  // sensors
  input wire logic [7:0] measured_position,
  input wire logic [7:0] motor_current_value,
  input wire logic over_temp,
  input wire logic under_voltage,
  input wire logic over_current,
  input wire logic internal_error,
  input wire logic [3:0] controller_fault_code,
  // motion engine commands
  output logic run_activation,
  output logic run_release,
  output logic release_opening,
  output logic move_enable,
  output logic [7:0] move_target,
  output logic [7:0] move_speed,
  output logic [7:0] move_force,
  output logic high_torque,
  output logic regrasp_enable,
  // fault indicator
  output logic led_blue,
  output logic led_red
);

  // gray coded along the usual path
  // release always exits to idle
  typedef enum logic [1:0] {
    GSR_IDLE = 2'b00,
    GSR_ACTIVATING = 2'b01,
    GSR_READY = 2'b11,
    GSR_RELEASING = 2'b10
  } gsr_state_t;

  // major band tops the code space
  // used by sequencer, mux and lamp
  function automatic logic gsr_is_major(input logic [3:0] code);
    gsr_is_major = code >= gsr_pkg::FLT_MAJOR_MIN;
  endfunction : gsr_is_major

  //////////////////////////////////////////////////////////////////////////////
  // command registers written by software
  logic [7:0] cmd_ff, nxt_cmd;
  logic [7:0] target_ff, nxt_target;
  logic [7:0] speed_ff, nxt_speed;
  logic [7:0] force_ff, nxt_force;
  logic [31:0] silence_ff, nxt_silence;
  logic comm_lost;
  // silence count saturates, so the
  // no-comm fault never self-clears
  // reads count as traffic as well
  // command bytes read back as written

  // any access counts as communication
  always_comb begin
    nxt_cmd = cmd_ff;
    nxt_target = target_ff;
    nxt_speed = speed_ff;
    nxt_force = force_ff;
    if (reg_wr) begin
      if (reg_addr == gsr_pkg::OFF_CMD) begin
        nxt_cmd = reg_wdata;
      end else if (reg_addr == gsr_pkg::OFF_TARGET_REQ) begin
        nxt_target = reg_wdata;
      end else if (reg_addr == gsr_pkg::OFF_SPEED_REQ) begin
        nxt_speed = reg_wdata;
      end else if (reg_addr == gsr_pkg::OFF_FORCE_REQ) begin
        nxt_force = reg_wdata;
      end
    end
    if (reg_wr || reg_rd) begin
      nxt_silence = '0;
    end else if (!comm_lost) begin
      nxt_silence = silence_ff + 32'h1;
    end else begin
      nxt_silence = silence_ff;
    end
  end

  // full-width compare, any timeout
  assign comm_lost = silence_ff >= 32'(COMM_TIMEOUT_CYC); // R11

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cmd_ff <= 8'h00;
      target_ff <= 8'h00;
      speed_ff <= 8'h00;
      force_ff <= 8'h00;
      silence_ff <= 32'h0;
    end else begin
      cmd_ff <= nxt_cmd;
      target_ff <= nxt_target;
      speed_ff <= nxt_speed;
      force_ff <= nxt_force;
      silence_ff <= nxt_silence;
    end
  end

  // named views of the command byte
  // positions shared with software
  wire logic act_cmd = cmd_ff[gsr_pkg::CMD_ACT];
  wire logic goto_cmd = cmd_ff[gsr_pkg::CMD_GTO];
  wire logic atr_cmd = cmd_ff[gsr_pkg::CMD_ATR];

  //////////////////////////////////////////////////////////////////////////////
  // activation / release sequencer and fault latch
  gsr_state_t state_ff, nxt_state;
  logic act_prev_ff, nxt_act_prev;
  logic [3:0] major_ff, nxt_major;
  logic rel_dir_ff, nxt_rel_dir;
  logic act_rise;

  // edge detect; history resets low,
  // the idle level: no edge at reset
  // a bit held high is no new edge:
  // clear and set it to leave a fault
  assign act_rise = act_cmd && !act_prev_ff;

  always_comb begin
    nxt_state = state_ff;
    nxt_act_prev = act_cmd;
    nxt_major = major_ff;
    nxt_rel_dir = rel_dir_ff;
    // major fault clears only on a fresh activation edge
    if (act_rise) begin
      nxt_major = gsr_pkg::FLT_NONE; // R12
    end
    case (state_ff)
      GSR_IDLE: begin
        if (act_cmd && !gsr_is_major(nxt_major)) begin
          nxt_state = GSR_ACTIVATING;
        end
      end
      GSR_ACTIVATING: begin
        if (activation_failed) begin
          nxt_major = gsr_pkg::FLT_ACT_FAIL; // R13
          nxt_state = GSR_IDLE;
        end else if (activation_done) begin
          nxt_state = GSR_READY;
        end
      end
      GSR_READY: begin
        if (atr_cmd) begin
          nxt_rel_dir = cmd_ff[gsr_pkg::CMD_ARD];
          nxt_state = GSR_RELEASING;
        end
      end
      // busy code reasserted each cycle
      // until the limits are reached
      default: begin
        nxt_major = gsr_pkg::FLT_REL_BUSY; // R13
        if (release_done) begin
          nxt_major = gsr_pkg::FLT_REL_DONE; // R23
          nxt_state = GSR_IDLE;
        end
      end
    endcase
    // live hardware faults; they win over sequencer codes
    if (under_voltage) begin
      nxt_major = gsr_pkg::FLT_UNDERVOLT;
    end else if (over_current) begin
      nxt_major = gsr_pkg::FLT_OVERCUR;
    end else if (internal_error) begin
      nxt_major = gsr_pkg::FLT_INTERNAL;
    end
    // clearing activation aborts everything; release keeps its own exit
    if (!act_cmd) begin
      nxt_state = GSR_IDLE;
    end else if (gsr_is_major(nxt_major) && state_ff != GSR_RELEASING) begin
      nxt_state = GSR_IDLE; // R12
    end
  end

  // sequencer and fault latch regs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff <= GSR_IDLE;
      act_prev_ff <= 1'b0;
      major_ff <= gsr_pkg::FLT_NONE;
      rel_dir_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      act_prev_ff <= nxt_act_prev;
      major_ff <= nxt_major;
      rel_dir_ff <= nxt_rel_dir;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // status fields and fault priority
  logic [1:0] sta_field;
  logic [1:0] obj_field;
  logic [3:0] gen_fault;

  // fields decode live; the read
  // flop is their only register
  // object field ignores go-to: the
  // host disregards it then
  always_comb begin
    case (state_ff)
      GSR_ACTIVATING: sta_field = gsr_pkg::STA_ACTIVATING; // R3
      GSR_READY: sta_field = gsr_pkg::STA_ACTIVE; // R3
      default: sta_field = gsr_pkg::STA_RESET; // R3
    endcase
    if (!motion_stopped) begin
      obj_field = gsr_pkg::OBJ_MOVING; // R4
    end else if (contact_detected && !closing_dir) begin
      obj_field = gsr_pkg::OBJ_OPEN_CONTACT; // R5
    end else if (contact_detected) begin
      obj_field = gsr_pkg::OBJ_CLOSE_CONTACT; // R6
    end else begin
      obj_field = gsr_pkg::OBJ_AT_TARGET; // R7
    end
    // major over minor over priority
    // one code fits the nibble; lower
    // classes reappear once it clears
    if (gsr_is_major(major_ff)) begin
      gen_fault = major_ff;
    end else if (over_temp) begin
      gen_fault = gsr_pkg::FLT_OVERTEMP; // R11
    end else if (comm_lost) begin
      gen_fault = gsr_pkg::FLT_NO_COMM; // R11
    end else if (goto_cmd && !act_cmd) begin
      gen_fault = gsr_pkg::FLT_NOT_ACTIVE; // R10
    end else if (goto_cmd && state_ff == GSR_ACTIVATING) begin
      gen_fault = gsr_pkg::FLT_DELAYED; // R10
    end else begin
      gen_fault = gsr_pkg::FLT_NONE; // R13
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // motion engine drive and force mode
  logic [7:0] state_byte;
  logic [$clog2(BLINK_CYC + 1)-1:0] blink_cnt_ff, nxt_blink_cnt;
  logic blink_ff, nxt_blink;
  logic [7:0] rdata_ff, nxt_rdata;

  // engine requests straight from
  // state: a major fault ends them next cycle, but not release
  // auto-release overrides go-to,
  // only release_done or clearing activation ends a running release, a major fault does not
  assign run_activation = state_ff == GSR_ACTIVATING; // R22
  assign run_release = state_ff == GSR_RELEASING; // R22
  assign release_opening = rel_dir_ff;
  assign move_enable = goto_cmd && state_ff == GSR_READY && !atr_cmd; // R21 R22 R23
  assign move_target = target_ff; // R21
  assign move_speed = speed_ff; // R21
  assign move_force = force_ff; // R21 R18
  // zero force also drops re-grasp
  assign high_torque = force_ff >= gsr_pkg::FORCE_HIGH_MIN; // R19 R20
  assign regrasp_enable = force_ff != 8'h00; // R18 R19 R20

  // byte zero: echo bits, state, object; others zero
  always_comb begin
    state_byte = 8'h00; // R25
    state_byte[gsr_pkg::BIT_ACT] = act_cmd; // R1
    state_byte[gsr_pkg::BIT_GTO] = goto_cmd; // R2
    state_byte[gsr_pkg::POS_STA +: 2] = sta_field;
    state_byte[gsr_pkg::POS_OBJ +: 2] = obj_field; // R9
  end

  //////////////////////////////////////////////////////////////////////////////
  // fault led blink divider and read mux
  // divider free-runs; a new major
  // fault may start mid-period
  // unmapped indexes read as zero
  // sensors sampled at the strobe,
  // so each byte is one coherent
  // reading
  always_comb begin
    nxt_blink = blink_ff;
    if (blink_cnt_ff >= ($bits(blink_cnt_ff))'(BLINK_CYC - 1)) begin
      nxt_blink_cnt = '0;
      nxt_blink = !blink_ff;
    end else begin
      nxt_blink_cnt = blink_cnt_ff + 1'b1;
    end
    nxt_rdata = 8'h00; // R25
    if (reg_rd) begin
      if (reg_addr == gsr_pkg::OFF_STATE_FLAGS) begin
        nxt_rdata = state_byte;
      end else if (reg_addr == gsr_pkg::OFF_FAULT) begin
        nxt_rdata = {controller_fault_code, gen_fault}; // R24
      end else if (reg_addr == gsr_pkg::OFF_TARGET_ECHO) begin
        nxt_rdata = target_ff; // R15
      end else if (reg_addr == gsr_pkg::OFF_MEAS_POS) begin
        nxt_rdata = measured_position; // R16
      end else if (reg_addr == gsr_pkg::OFF_CURRENT) begin
        nxt_rdata = motor_current_value; // R17
      end else if (reg_addr == gsr_pkg::OFF_CMD) begin
        nxt_rdata = cmd_ff;
      end else if (reg_addr == gsr_pkg::OFF_TARGET_REQ) begin
        nxt_rdata = target_ff;
      end else if (reg_addr == gsr_pkg::OFF_SPEED_REQ) begin
        nxt_rdata = speed_ff;
      end else if (reg_addr == gsr_pkg::OFF_FORCE_REQ) begin
        nxt_rdata = force_ff;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      blink_cnt_ff <= '0;
      blink_ff <= 1'b0;
      rdata_ff <= 8'h00;
    end else begin
      blink_cnt_ff <= nxt_blink_cnt;
      blink_ff <= nxt_blink;
      rdata_ff <= nxt_rdata;
    end
  end

  // one cycle latency, no glitches
  assign reg_rdata = rdata_ff;

  // lamp follows the reported code,
  // never disagrees with the byte
  // major blinks alternately, minor solid red, else blue
  assign led_red = gsr_is_major(gen_fault) ? blink_ff : (gen_fault >= gsr_pkg::FLT_MINOR_MIN); // R14
  assign led_blue = gsr_is_major(gen_fault) ? !blink_ff : (gen_fault < gsr_pkg::FLT_MINOR_MIN); // R14

endmodule : gsr_status_regs
`default_nettype wire

// ### verification/gsr_status_regs_checker.sv
// Purpose: port-level checks of the gripper status register bank
// Assumes: read data registered, valid only the cycle after the read strobe
// Notes: attached by bind below
`timescale 1ns/10ps
`default_nettype none
module gsr_status_regs_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [7:0] measured_position,
  input wire logic [7:0] motor_current_value,
  input wire logic [3:0] controller_fault_code,
  input wire logic [7:0] move_target,
  input wire logic [7:0] move_force,
  input wire logic high_torque,
  input wire logic regrasp_enable,
  input wire logic move_enable,
  input wire logic run_activation,
  input wire logic run_release
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////
  // read data per status byte, one cycle after the strobe; zero after a cycle with no strobe
  property p_rsvd;
    reg_rd && reg_addr == gsr_pkg::OFF_RESERVED |=> reg_rdata == 8'h00;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved byte not zero");
  property p_flags;
    reg_rd && reg_addr == gsr_pkg::OFF_STATE_FLAGS |=> reg_rdata[5:4] != 2'h2 && reg_rdata[2:1] == 2'h0;
  endproperty
  a_flags: assert property (p_flags) else $error("bad state flags byte");
  property p_idle;
    !reg_rd |=> reg_rdata == 8'h00;
  endproperty
  a_idle: assert property (p_idle) else $error("read data outside read slot");
  property p_tgt;
    reg_rd && reg_addr == gsr_pkg::OFF_TARGET_ECHO |=> reg_rdata == $past(move_target);
  endproperty
  a_tgt: assert property (p_tgt) else $error("target echo wrong");
  property p_pos;
    reg_rd && reg_addr == gsr_pkg::OFF_MEAS_POS |=> reg_rdata == $past(measured_position);
  endproperty
  a_pos: assert property (p_pos) else $error("position byte wrong");
  property p_cur;
    reg_rd && reg_addr == gsr_pkg::OFF_CURRENT |=> reg_rdata == $past(motor_current_value);
  endproperty
  a_cur: assert property (p_cur) else $error("current byte wrong");
  property p_controller_fault_code;
    reg_rd && reg_addr == gsr_pkg::OFF_FAULT |=> reg_rdata[7:4] == $past(controller_fault_code);
  endproperty
  a_controller_fault_code: assert property (p_controller_fault_code) else $error("fault high nibble wrong");
  ////////////////////////////////////////////////////////////////////////////
  // motion and force decode
  property p_move;
    move_enable |-> !run_activation && !run_release;
  endproperty
  a_move: assert property (p_move) else $error("move during routine");
  property p_torque;
    high_torque == move_force[7];
  endproperty
  a_torque: assert property (p_torque) else $error("torque band wrong");
  property p_regrasp;
    regrasp_enable == (move_force != 8'h00);
  endproperty
  a_regrasp: assert property (p_regrasp) else $error("regrasp wrong");
endmodule : gsr_status_regs_checker
bind gsr_status_regs gsr_status_regs_checker i_chk (.clk(clk), .rst(rst), .reg_addr(reg_addr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .measured_position(measured_position),
  .motor_current_value(motor_current_value), .controller_fault_code(controller_fault_code),
  .move_target(move_target), .move_force(move_force), .high_torque(high_torque),
  .regrasp_enable(regrasp_enable), .move_enable(move_enable),
  .run_activation(run_activation), .run_release(run_release));
`default_nettype wire

// ### verification/gsr_motion_model.sv
// Purpose: behavioural finger drive beside the status bank
// Assumes: one position count per cycle, routines settle in 8 cycles
// Notes: obstacle inputs let the bench make contact on purpose
`timescale 1ns/10ps
`default_nettype none
module gsr_motion_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic run_activation,
  input wire logic run_release,
  input wire logic move_enable,
  input wire logic [7:0] move_target,
  input wire logic obst_en,
  input wire logic [7:0] obst_pos,
  input wire logic act_fail_en,
  output logic activation_done,
  output logic activation_failed,
  output logic release_done,
  output logic motion_stopped,
  output logic contact_detected,
  output logic closing_dir,
  output logic [7:0] measured_position
);
  logic [3:0] cnt_ff, nxt_cnt;
  logic [7:0] pos_ff, nxt_pos;
  logic dir_ff, nxt_dir, contact;
  assign contact = obst_en && pos_ff == obst_pos;
  // routine timer and finger stepping; stops dead on the obstacle
  always_comb begin
    nxt_cnt = 4'h0;
    if (run_activation || run_release) nxt_cnt = (cnt_ff == 4'hf) ? cnt_ff : cnt_ff + 4'h1;
    nxt_pos = pos_ff;
    nxt_dir = dir_ff;
    if (move_enable && !contact && pos_ff != move_target) begin
      nxt_dir = move_target > pos_ff;
      nxt_pos = nxt_dir ? pos_ff + 8'h01 : pos_ff - 8'h01;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_ff <= 4'h0;
      pos_ff <= 8'h00;
      dir_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      pos_ff <= nxt_pos;
      dir_ff <= nxt_dir;
    end
  end
  // failure only on request, midway through the routine
  assign activation_failed = run_activation && act_fail_en && cnt_ff == 4'h4;
  assign activation_done = run_activation && cnt_ff >= 4'h8;
  assign release_done = run_release && cnt_ff >= 4'h8;
  assign motion_stopped = !move_enable || contact || pos_ff == move_target;
  assign contact_detected = move_enable && contact;
  assign closing_dir = dir_ff;
  assign measured_position = pos_ff;
endmodule : gsr_motion_model
`default_nettype wire

// ### verification/tb_gsr_status_regs.sv
// Purpose: self-checking bench of the gripper status register bank
// Assumes: short comm timeout and blink counts set by parameter
// Notes: reads note expectations in a queue, a monitor compares them
`timescale 1ns/10ps
`default_nettype none
module tb_gsr_status_regs;
  localparam int COMM = 300;
  logic clk, rst, reg_wr, reg_rd, over_temp, under_voltage, over_current, internal_error;
  logic activation_done, activation_failed, motion_stopped, contact_detected, closing_dir;
  logic release_done, run_activation, run_release, release_opening, move_enable;
  logic high_torque, regrasp_enable, led_blue, led_red, obst_en, rd_d, r1, r0, act_fail_en;
  logic [3:0] reg_addr, controller_fault_code, cfc;
  logic [7:0] reg_wdata, reg_rdata, measured_position, motor_current_value, obst_pos, last, t;
  logic [7:0] move_target, move_force, move_speed;
  logic [7:0] frc [5] = '{8'h00, 8'h01, 8'h7f, 8'h80, 8'hff};
  logic [15:0] exp_q [$];
  logic [15:0] qe;
  int err_count, total_checks;
  integer seed;
  gsr_status_regs #(.COMM_TIMEOUT_CYC(COMM), .BLINK_CYC(4)) i_gsr_status_regs (.clk(clk),
    .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .activation_done(activation_done),
    .activation_failed(activation_failed), .motion_stopped(motion_stopped),
    .contact_detected(contact_detected), .closing_dir(closing_dir),
    .release_done(release_done), .measured_position(measured_position),
    .motor_current_value(motor_current_value), .over_temp(over_temp),
    .under_voltage(under_voltage), .over_current(over_current),
    .internal_error(internal_error), .controller_fault_code(controller_fault_code),
    .run_activation(run_activation), .run_release(run_release),
    .release_opening(release_opening), .move_enable(move_enable), .move_target(move_target),
    .move_speed(move_speed), .move_force(move_force), .high_torque(high_torque),
    .regrasp_enable(regrasp_enable), .led_blue(led_blue), .led_red(led_red));
  gsr_motion_model i_gsr_motion_model (.clk(clk), .rst(rst), .run_activation(run_activation),
    .run_release(run_release), .move_enable(move_enable), .move_target(move_target),
    .obst_en(obst_en), .obst_pos(obst_pos), .act_fail_en(act_fail_en),
    .activation_done(activation_done),
    .activation_failed(activation_failed), .release_done(release_done),
    .motion_stopped(motion_stopped), .contact_detected(contact_detected),
    .closing_dir(closing_dir), .measured_position(measured_position));
  ////////////////////////////////////////////////////////////////////////////
  always #5 clk = ~clk;
  task automatic report_and_stop;
    if (err_count == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr
  // mask zero notes a read whose value only steers a wait
  task automatic rd(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    exp_q.push_back({m, e});
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 last = reg_rdata;
  endtask : rd
  task automatic poll(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
    int n;
    n = 0;
    rd(a, 8'h00, 8'h00);
    while ((last & m) !== e) begin
      n++;
      if (n > 400) begin
        err_count++;
        $display("ERROR %0t: wait ran out", $time);
        report_and_stop();
      end
      rd(a, 8'h00, 8'h00);
    end
  endtask : poll
  // read data stands only in the cycle after the strobe
  always @(posedge clk) begin
    rd_d <= reg_rd;
    motor_current_value <= 8'($random(seed));
    if (rd_d) begin
      qe = exp_q.pop_front();
      if (qe[15:8] !== 8'h00) chk(reg_rdata & qe[15:8], qe[7:0] & qe[15:8]);
    end
  end
  initial begin
    repeat (60000) @(posedge clk);
    err_count++;
    report_and_stop();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {clk, reg_wr, reg_rd, over_temp, under_voltage, over_current, internal_error} = '0;
    {reg_addr, reg_wdata, obst_en, obst_pos, motor_current_value, rd_d, act_fail_en} = '0;
    rst = 1'b1;
    seed = 32'hdf9bd675;
    cfc = 4'($random(seed));
    controller_fault_code = cfc;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rd(gsr_pkg::OFF_STATE_FLAGS, 8'h00, 8'h3f);
    rd(gsr_pkg::OFF_RESERVED, 8'h00, 8'hff);
    rd(gsr_pkg::OFF_FAULT, {cfc, gsr_pkg::FLT_NONE}, 8'hff);
    rd(4'hc, 8'h00, 8'hff);
    chk({6'h0, led_red, led_blue}, 8'h01);
    foreach (frc[i]) begin
      wr(gsr_pkg::OFF_FORCE_REQ, frc[i]);
      chk({7'h0, high_torque}, {7'h0, frc[i] >= 8'h80});
      chk({7'h0, regrasp_enable}, {7'h0, frc[i] != 8'h00});
      chk(move_force, frc[i]);
    end
    t = 8'($random(seed));
    wr(gsr_pkg::OFF_TARGET_REQ, t);
    chk(move_target, t);
    rd(gsr_pkg::OFF_TARGET_ECHO, t, 8'hff);
    wr(gsr_pkg::OFF_SPEED_REQ, t);
    chk(move_speed, t);
    rd(gsr_pkg::OFF_SPEED_REQ, t, 8'hff);
    wr(gsr_pkg::OFF_TARGET_REQ, 8'hc0);
    wr(gsr_pkg::OFF_CMD, 8'h08);
    rd(gsr_pkg::OFF_STATE_FLAGS, 8'h08, 8'h3f);
    rd(gsr_pkg::OFF_FAULT, {cfc, gsr_pkg::FLT_NOT_ACTIVE}, 8'hff);
    obst_pos <= 8'h60;
    obst_en <= 1'b1;
    wr(gsr_pkg::OFF_CMD, 8'h09);
    rd(gsr_pkg::OFF_STATE_FLAGS, 8'h19, 8'h3f);
    rd(gsr_pkg::OFF_FAULT, {cfc, gsr_pkg::FLT_DELAYED}, 8'hff);
    poll(gsr_pkg::OFF_STATE_FLAGS, 8'h30, 8'h30);
    rd(gsr_pkg::OFF_STATE_FLAGS, 8'h39, 8'hff);
    poll(gsr_pkg::OFF_STATE_FLAGS, 8'hc0, 8'h80);
    rd(gsr_pkg::OFF_MEAS_POS, 8'h60, 8'hff);
    obst_en <= 1'b0;
    poll(gsr_pkg::OFF_STATE_FLAGS, 8'hc0, 8'hc0);
    rd(gsr_pkg::OFF_MEAS_POS, 8'hc0, 8'hff);
    obst_pos <= 8'h80;
    obst_en <= 1'b1;
    wr(gsr_pkg::OFF_TARGET_REQ, 8'h10);
    poll(gsr_pkg::OFF_STATE_FLAGS, 8'hc0, 8'h40);
    rd(gsr_pkg::OFF_MEAS_POS, 8'h80, 8'hff);
    obst_en <= 1'b0;
    over_temp <= 1'b1;
    @(posedge clk);
    rd(gsr_pkg::OFF_FAULT, {cfc, gsr_pkg::FLT_OVERTEMP}, 8'hff);
    chk({6'h0, led_red, led_blue}, 8'h02);
    over_temp <= 1'b0;
    repeat (COMM + 10) @(posedge clk);
    rd(gsr_pkg::OFF_FAULT, {cfc, gsr_pkg::FLT_NO_COMM}, 8'hff);
    under_voltage <= 1'b1;
    repeat (2) @(posedge clk);
    under_voltage <= 1'b0;
    rd(gsr_pkg::OFF_FAULT, {cfc, gsr_pkg::FLT_UNDERVOLT}, 8'hff);
    {r1, r0} = 2'b00;
    // blink seen as both levels of the red lamp
    repeat (12) begin
      @(posedge clk);
      r1 = r1 | led_red;
      r0 = r0 | !led_red;
    end
    chk({6'h0, r1, r0}, 8'h03);
    wr(gsr_pkg::OFF_CMD, 8'h00);
    wr(gsr_pkg::OFF_CMD, 8'h01);
    poll(gsr_pkg::OFF_STATE_FLAGS, 8'h30, 8'h30);
    rd(gsr_pkg::OFF_FAULT, {cfc, gsr_pkg::FLT_NONE}, 8'hff);
    wr(gsr_pkg::OFF_CMD, 8'h31);
    @(posedge clk);
    rd(gsr_pkg::OFF_FAULT, {cfc, gsr_pkg::FLT_REL_BUSY}, 8'hff);
    chk({7'h0, release_opening}, 8'h01);
    poll(gsr_pkg::OFF_FAULT, 8'h0f, 8'h0f);
    rd(gsr_pkg::OFF_STATE_FLAGS, 8'h01, 8'h3f);
    wr(gsr_pkg::OFF_CMD, 8'h39);
    rd(gsr_pkg::OFF_FAULT, {cfc, gsr_pkg::FLT_REL_DONE}, 8'hff);
    chk({7'h0, move_enable}, 8'h00);
    wr(gsr_pkg::OFF_CMD, 8'h00);
    act_fail_en <= 1'b1;
    wr(gsr_pkg::OFF_CMD, 8'h01);
    poll(gsr_pkg::OFF_FAULT, 8'h0f, 8'h0d);
    rd(gsr_pkg::OFF_FAULT, {cfc, gsr_pkg::FLT_ACT_FAIL}, 8'hff);
    report_and_stop();
  end
endmodule : tb_gsr_status_regs
`default_nettype wire
